/* design/pmc_pkg.sv */
// Package for the power monitor calibration block: register map, reset values, limits
package pmc_pkg;
	localparam int unsigned PMC_ADDR_W = 4;
	localparam logic [3:0] PMC_OFS_CTRL = 4'h0;
	localparam logic [3:0] PMC_OFS_STATUS = 4'h1;
	localparam logic [3:0] PMC_OFS_GAIN_I = 4'h2;
	localparam logic [3:0] PMC_OFS_GAIN_V = 4'h3;
	localparam logic [3:0] PMC_OFS_GAIN_P = 4'h4;
	localparam logic [3:0] PMC_OFS_EXP_I = 4'h5;
	localparam logic [3:0] PMC_OFS_EXP_V = 4'h6;
	localparam logic [3:0] PMC_OFS_EXP_P = 4'h7;
	localparam logic [3:0] PMC_OFS_RANGE = 4'h8;
	localparam logic [3:0] PMC_OFS_PHASE = 4'h9;
	localparam logic [3:0] PMC_OFS_PHASE_ADJ = 4'hA;
	localparam logic [3:0] PMC_OFS_DC_OFS_I = 4'hB;
	localparam logic [3:0] PMC_OFS_AC_OFS_I = 4'hC;
	localparam logic [3:0] PMC_OFS_AC_OFS_P = 4'hD;
	localparam logic [3:0] PMC_OFS_AC_OFS_Q = 4'hE;
	localparam logic [3:0] PMC_OFS_GAIN_F = 4'hF;
	// Control register bit positions (write 1 to start; PMC_CTRL_DC_MODE is a level, loaded on every control write)
	localparam int unsigned PMC_CTRL_GAIN_CAL = 0;
	localparam int unsigned PMC_CTRL_FREQ_CAL = 1;
	localparam int unsigned PMC_CTRL_PHASE_UPD = 2;
	localparam int unsigned PMC_CTRL_DC_MODE = 3;
	// Status register bit positions
	localparam int unsigned PMC_ST_BUSY = 0;
	localparam int unsigned PMC_ST_ACK = 1;
	localparam int unsigned PMC_ST_NAK = 2;
	localparam logic [15:0] PMC_GAIN_MIN = 16'h61A8;
	localparam logic [15:0] PMC_GAIN_MAX = 16'hFFFF;
	localparam logic [15:0] PMC_GAIN_RST = 16'h8000;
	localparam logic [4:0] PMC_RANGE_RST = 5'h0C;
	localparam logic signed [7:0] PMC_PHASE_LIM = 8'sh7F;
	localparam int unsigned PMC_DIV_CYCLES = 40;
	typedef enum logic [2:0] {PMC_IDLE, PMC_DIV, PMC_NEXT, PMC_DONE} pmc_state_t;
endpackage : pmc_pkg

/* design/pmc_calib.sv */
// Calibration engine: gain auto-calibration, range scaling, phase and offset correction
//Contract
//RL1: Gain command rescales current, voltage, power gains by expected over measured.
//RL2: ACK only if all three new gains lie in 25000..65535, else NAK.
//RL3: Gains are unsigned 16-bit; results must fit.
//RL4: Current RMS product shifted right by range count.
//RL5: Host may save constants to flash after ACK.
//RL6: Host converts angle error to units by multiplying by 40.
//RL7: New phase is old plus adjustment, 8-bit two's complement in low byte.
//RL8: Phase correction limited to about plus or minus 3.2 degrees.
//RL9: DC offset added to current converter output before anything else.
//RL10: DC mode bypasses high-pass filters on current and voltage.
//RL11: Three AC offset registers: current RMS, active and reactive power.
//RL12: Host order: temperature, frequency, gain, phase, reactive gain.
//RL13: Host copies thermistor voltage to ambient reference first when sensor fitted.
//RL14: Host runs frequency calibration second, only on internal oscillator.
//RL15: With filters on, host needs only single-point gain calibration.
//RL16: Host calibrates phase near power factor 0.5.
//RL17: Host picks range putting gain mid bounds.
//RL18: Frequency command sets frequency gain so measured matches reference.
//RL19: On NAK all three gains keep previous values.
`timescale 1ns/1ps
module pmc_calib
	import pmc_pkg::*;
#(
	parameter int unsigned DATA_W = 24
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [PMC_ADDR_W-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic signed [DATA_W-1:0] adc_i_i,
	input wire logic signed [DATA_W-1:0] hpf_i_i,
	input wire logic signed [DATA_W-1:0] hpf_v_i,
	input wire logic signed [DATA_W-1:0] raw_v_i,
	input wire logic [15:0] meas_i_i,
	input wire logic [15:0] meas_v_i,
	input wire logic [15:0] meas_p_i,
	input wire logic [15:0] meas_f_i,
	input wire logic [15:0] ref_f_i,
	input wire logic [DATA_W-1:0] irms_raw_i,
	output logic signed [DATA_W-1:0] adc_i_corr_o,
	output logic signed [DATA_W-1:0] chan_i_o,
	output logic signed [DATA_W-1:0] chan_v_o,
	output logic [DATA_W-1:0] irms_o,
	output logic done_o,
	output logic ack_o
);
	logic [15:0] gain_reg [3];
	logic [15:0] exp_reg [3];
	logic [15:0] gain_f_reg;
	logic [4:0] range_reg;
	logic [15:0] phase_reg;
	logic [7:0] phase_adj_reg;
	logic [15:0] dc_ofs_reg;
	logic [15:0] ac_ofs_reg [3];
	logic dc_mode_reg;
	logic ack_reg, nak_reg, done_reg;
	logic [15:0] new_gain_reg [3];
	logic fail_reg;
	logic [1:0] idx_reg;
	logic freq_mode_reg;
	logic [5:0] cnt_reg;
	logic [31:0] rem_reg, quot_reg, den_reg;
	pmc_state_t state_reg;
	logic [DATA_W-1:0] irms_next;

	function automatic logic [15:0] meas_sel(input logic [1:0] i, input logic [15:0] a,
			input logic [15:0] b, input logic [15:0] c);
		return (i == 2'd0) ? a : (i == 2'd1) ? b : c;
	endfunction : meas_sel

	function automatic logic in_limits(input logic [31:0] g);
		return (g >= 32'(PMC_GAIN_MIN)) && (g <= 32'(PMC_GAIN_MAX)); // RL2 RL3
	endfunction : in_limits

	wire logic start_gain = wr_i && addr_i == PMC_OFS_CTRL && wdata_i[PMC_CTRL_GAIN_CAL];
	wire logic start_freq = wr_i && addr_i == PMC_OFS_CTRL && wdata_i[PMC_CTRL_FREQ_CAL];
	wire logic phase_upd = wr_i && addr_i == PMC_OFS_CTRL && wdata_i[PMC_CTRL_PHASE_UPD];
	wire logic busy = state_reg != PMC_IDLE;
	wire logic [15:0] cur_meas = freq_mode_reg ? meas_f_i : meas_sel(idx_reg, meas_i_i, meas_v_i, meas_p_i);
	wire logic [15:0] cur_exp = freq_mode_reg ? ref_f_i : exp_reg[idx_reg];
	wire logic [15:0] cur_gain = freq_mode_reg ? gain_f_reg : gain_reg[idx_reg];
	wire logic signed [8:0] phase_sum = 9'($signed(phase_reg[7:0])) + 9'($signed(phase_adj_reg));

	// Restoring divider: old gain times expected, over measured
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= PMC_IDLE;
			idx_reg <= 2'd0;
			cnt_reg <= 6'd0;
			rem_reg <= 32'd0;
			quot_reg <= 32'd0;
			den_reg <= 32'd0;
			fail_reg <= 1'b0;
			freq_mode_reg <= 1'b0;
			for (int k = 0; k < 3; k++) begin
				new_gain_reg[k] <= 16'h0000;
			end
		end else begin
			unique case (state_reg)
				PMC_IDLE: begin
					if (start_gain || start_freq) begin
						freq_mode_reg <= start_freq && !start_gain;
						idx_reg <= 2'd0;
						fail_reg <= 1'b0;
						state_reg <= PMC_NEXT;
					end
				end
				PMC_NEXT: begin
					rem_reg <= 32'd0;
					quot_reg <= 32'(cur_gain) * 32'(cur_exp);
					den_reg <= 32'(cur_meas);
					cnt_reg <= 6'd0;
					state_reg <= PMC_DIV;
				end
				PMC_DIV: begin
					// Index moves on only here, so it stays within the three gains
					if (cnt_reg == 6'(PMC_DIV_CYCLES - 1)) begin
						if (freq_mode_reg || idx_reg == 2'd2) begin
							state_reg <= PMC_DONE;
						end else begin
							idx_reg <= idx_reg + 2'd1;
							state_reg <= PMC_NEXT;
						end
					end
					if (cnt_reg < 6'd32) begin
						if ({rem_reg[30:0], quot_reg[31]} >= den_reg) begin
							rem_reg <= {rem_reg[30:0], quot_reg[31]} - den_reg;
							quot_reg <= {quot_reg[30:0], 1'b1};
						end else begin
							rem_reg <= {rem_reg[30:0], quot_reg[31]};
							quot_reg <= {quot_reg[30:0], 1'b0};
						end
					end else if (cnt_reg == 6'd32) begin
						new_gain_reg[idx_reg] <= quot_reg[15:0]; // RL1
						if (den_reg == 32'd0 || !in_limits(quot_reg)) begin
							fail_reg <= 1'b1; // RL2
						end
					end
					cnt_reg <= cnt_reg + 6'd1;
				end
				PMC_DONE: state_reg <= PMC_IDLE;
				default: state_reg <= PMC_IDLE;
			endcase
		end
	end

	// Gains commit only on a passing calibration
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int k = 0; k < 3; k++) begin
				gain_reg[k] <= PMC_GAIN_RST;
			end
			gain_f_reg <= PMC_GAIN_RST;
		end else if (state_reg == PMC_DONE && !fail_reg) begin
			if (freq_mode_reg) begin
				gain_f_reg <= new_gain_reg[0]; // RL18
			end else begin
				for (int k = 0; k < 3; k++) begin
					gain_reg[k] <= new_gain_reg[k]; // RL1 RL19
				end
			end
		end else if (wr_i && !busy) begin
			if (addr_i == PMC_OFS_GAIN_I) gain_reg[0] <= wdata_i;
			if (addr_i == PMC_OFS_GAIN_V) gain_reg[1] <= wdata_i;
			if (addr_i == PMC_OFS_GAIN_P) gain_reg[2] <= wdata_i;
			if (addr_i == PMC_OFS_GAIN_F) gain_f_reg <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_reg <= 1'b0;
			nak_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= state_reg == PMC_DONE;
			if (state_reg == PMC_DONE) begin
				ack_reg <= !fail_reg; // RL2
				nak_reg <= fail_reg;
			end else if (!busy && (start_gain || start_freq)) begin
				ack_reg <= 1'b0;
				nak_reg <= 1'b0;
			end
		end
	end

	// Plain configuration registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int k = 0; k < 3; k++) begin
				exp_reg[k] <= 16'h0000;
				ac_ofs_reg[k] <= 16'h0000;
			end
			range_reg <= PMC_RANGE_RST;
			phase_adj_reg <= 8'h00;
			dc_ofs_reg <= 16'h0000;
			dc_mode_reg <= 1'b0;
		end else if (wr_i) begin
			unique case (addr_i)
				PMC_OFS_CTRL: dc_mode_reg <= wdata_i[PMC_CTRL_DC_MODE];
				PMC_OFS_EXP_I: exp_reg[0] <= wdata_i;
				PMC_OFS_EXP_V: exp_reg[1] <= wdata_i;
				PMC_OFS_EXP_P: exp_reg[2] <= wdata_i;
				PMC_OFS_RANGE: range_reg <= wdata_i[4:0];
				PMC_OFS_PHASE_ADJ: phase_adj_reg <= wdata_i[7:0];
				PMC_OFS_DC_OFS_I: dc_ofs_reg <= wdata_i;
				PMC_OFS_AC_OFS_I: ac_ofs_reg[0] <= wdata_i; // RL11
				PMC_OFS_AC_OFS_P: ac_ofs_reg[1] <= wdata_i; // RL11
				PMC_OFS_AC_OFS_Q: ac_ofs_reg[2] <= wdata_i; // RL11
				default: ;
			endcase
		end
	end

	// Phase accumulate saturates at the 8-bit limit rather than wrapping
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_reg <= 16'h0000;
		end else if (phase_upd) begin
			if (phase_sum > 9'sd127) phase_reg <= {8'h00, PMC_PHASE_LIM}; // RL8
			else if (phase_sum < -9'sd128) phase_reg <= 16'h0080; // RL8
			else phase_reg <= {8'h00, phase_sum[7:0]}; // RL7
		end else if (wr_i && addr_i == PMC_OFS_PHASE) begin
			phase_reg <= {8'h00, wdata_i[7:0]}; // RL7
		end
	end

	// Datapath
	always_comb begin
		irms_next = DATA_W'((48'(irms_raw_i) * 48'(gain_reg[0])) >> range_reg); // RL4
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			adc_i_corr_o <= '0;
			chan_i_o <= '0;
			chan_v_o <= '0;
			irms_o <= '0;
		end else begin
			adc_i_corr_o <= adc_i_i + DATA_W'($signed(dc_ofs_reg)); // RL9
			chan_i_o <= dc_mode_reg ? adc_i_corr_o : hpf_i_i; // RL10
			chan_v_o <= dc_mode_reg ? raw_v_i : hpf_v_i; // RL10
			irms_o <= irms_next;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			unique case (addr_i)
				PMC_OFS_CTRL: rdata_o <= {12'h000, dc_mode_reg, 3'b000};
				PMC_OFS_STATUS: rdata_o <= {13'h0000, nak_reg, ack_reg, busy};
				PMC_OFS_GAIN_I: rdata_o <= gain_reg[0];
				PMC_OFS_GAIN_V: rdata_o <= gain_reg[1];
				PMC_OFS_GAIN_P: rdata_o <= gain_reg[2];
				PMC_OFS_EXP_I: rdata_o <= exp_reg[0];
				PMC_OFS_EXP_V: rdata_o <= exp_reg[1];
				PMC_OFS_EXP_P: rdata_o <= exp_reg[2];
				PMC_OFS_RANGE: rdata_o <= {11'h000, range_reg};
				PMC_OFS_PHASE: rdata_o <= phase_reg;
				PMC_OFS_PHASE_ADJ: rdata_o <= {8'h00, phase_adj_reg};
				PMC_OFS_DC_OFS_I: rdata_o <= dc_ofs_reg;
				PMC_OFS_AC_OFS_I: rdata_o <= ac_ofs_reg[0];
				PMC_OFS_AC_OFS_P: rdata_o <= ac_ofs_reg[1];
				PMC_OFS_AC_OFS_Q: rdata_o <= ac_ofs_reg[2];
				PMC_OFS_GAIN_F: rdata_o <= gain_f_reg;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	assign done_o = done_reg;
	assign ack_o = ack_reg;

	property p_nak_keeps;
		@(posedge clk_i) disable iff (!reset_n_i)
		(state_reg == PMC_DONE && fail_reg && !freq_mode_reg) |=> $stable(gain_reg[0]) && $stable(gain_reg[1])
			&& $stable(gain_reg[2]);
	endproperty
	a_nak_keeps: assert property (p_nak_keeps) else $error("gain changed on failed calibration"); // RL19
	property p_ack_limits;
		@(posedge clk_i) disable iff (!reset_n_i)
		(state_reg == PMC_DONE && !fail_reg && !freq_mode_reg) |=> gain_reg[0] >= PMC_GAIN_MIN
			&& gain_reg[1] >= PMC_GAIN_MIN && gain_reg[2] >= PMC_GAIN_MIN;
	endproperty
	a_ack_limits: assert property (p_ack_limits) else $error("accepted gain below limit"); // RL2
	property p_done_ack;
		@(posedge clk_i) disable iff (!reset_n_i)
		done_o |-> (ack_reg != nak_reg);
	endproperty
	a_done_ack: assert property (p_done_ack) else $error("answer not exclusive"); // RL2
	property p_gain_dur;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(busy) && !freq_mode_reg |-> ##[120:130] done_o;
	endproperty
	a_gain_dur: assert property (p_gain_dur) else $error("gain calibration length wrong"); // RL1
	property p_dc_ofs;
		@(posedge clk_i) disable iff (!reset_n_i)
		##1 adc_i_corr_o == $past(adc_i_i) + DATA_W'($signed($past(dc_ofs_reg)));
	endproperty
	a_dc_ofs: assert property (p_dc_ofs) else $error("dc offset not applied"); // RL9
	property p_dc_bypass;
		@(posedge clk_i) disable iff (!reset_n_i)
		$past(dc_mode_reg) |-> chan_v_o == $past(raw_v_i) && chan_i_o == $past(adc_i_corr_o);
	endproperty
	a_dc_bypass: assert property (p_dc_bypass) else $error("filter not bypassed"); // RL10
	property p_range;
		@(posedge clk_i) disable iff (!reset_n_i)
		##1 irms_o == $past(irms_next);
	endproperty
	a_range: assert property (p_range) else $error("scaled rms mismatch"); // RL4
	property p_phase_hi;
		@(posedge clk_i) disable iff (!reset_n_i)
		phase_upd |=> phase_reg[15:8] == 8'h00 && ($past(phase_sum) > 9'sd127 || $past(phase_sum) < -9'sd128
			|| phase_reg[7:0] == 8'($past(phase_reg[7:0]) + $past(phase_adj_reg)));
	endproperty
	a_phase_hi: assert property (p_phase_hi) else $error("phase high byte set"); // RL7
	c_ack: cover property (@(posedge clk_i) done_o && ack_o);
	c_nak: cover property (@(posedge clk_i) done_o && !ack_o);
	c_freq: cover property (@(posedge clk_i) state_reg == PMC_DONE && freq_mode_reg);
	c_phase_sat: cover property (@(posedge clk_i) phase_upd && phase_sum > 9'sd127);
endmodule : pmc_calib

/* test/pmc_host_model.sv */
// Host controller model: register bus master issuing calibration commands
`timescale 1ns/1ps
module pmc_host_model
	import pmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output logic [PMC_ADDR_W-1:0] addr_o,
	output logic [15:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		addr_o = '0;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr(input logic [PMC_ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d; // Stale data must not look valid
	endtask : wr
	task automatic rd(input logic [PMC_ADDR_W-1:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask : rd
	// No sensor fitted and gains never saved, so those steps are skipped
	task automatic cmd(input logic [15:0] bits);
		wr(PMC_OFS_CTRL, bits);
	endtask : cmd
	function automatic logic [15:0] phase_units(input int deg);
		return 16'(deg * 40);
	endfunction : phase_units
endmodule : pmc_host_model

/* test/tb.sv */
// Self-checking bench for the calibration engine
`timescale 1ns/1ps
module tb;
	import pmc_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [PMC_ADDR_W-1:0] addr_i;
	logic [15:0] wdata_i, rdata_o, rv;
	logic wr_i, rd_i, done_o, ack_o;
	logic signed [23:0] adc_i_i, hpf_i_i, hpf_v_i, raw_v_i;
	logic signed [23:0] adc_i_corr_o, chan_i_o, chan_v_o;
	logic [15:0] meas_i_i, meas_v_i, meas_p_i;
	logic [15:0] meas_f_i, ref_f_i;
	logic [23:0] irms_raw_i, irms_o;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	always #5 clk_i = ~clk_i;
	pmc_host_model host (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
		.rd_o(rd_i));
	pmc_calib dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .adc_i_i(adc_i_i), .hpf_i_i(hpf_i_i), .hpf_v_i(hpf_v_i),
		.raw_v_i(raw_v_i), .meas_i_i(meas_i_i), .meas_v_i(meas_v_i), .meas_p_i(meas_p_i), .meas_f_i(meas_f_i),
		.ref_f_i(ref_f_i), .irms_raw_i(irms_raw_i), .adc_i_corr_o(adc_i_corr_o), .chan_i_o(chan_i_o),
		.chan_v_o(chan_v_o), .irms_o(irms_o), .done_o(done_o), .ack_o(ack_o));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rchk(input string what, input logic [PMC_ADDR_W-1:0] a, input logic [15:0] exp);
		host.rd(a, rv);
		chk(what, {8'h00, exp}, {8'h00, rv});
	endtask : rchk
	// Bounded wait: a lost done pulse must not hang the run
	task automatic wait_done();
		for (int i = 0; i < 200; i++) begin
			@(posedge clk_i);
			#1;
			if (done_o === 1'b1)
				return;
		end
		chk("done_o", 24'h00_0001, 24'h00_0000);
	endtask : wait_done
	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask : settle
	task automatic t_reset();
		rchk("gain_i", PMC_OFS_GAIN_I, 16'h8000);
		rchk("gain_v", PMC_OFS_GAIN_V, 16'h8000);
		rchk("gain_p", PMC_OFS_GAIN_P, 16'h8000);
		rchk("range", PMC_OFS_RANGE, 16'h000C);
		$display("reset test done");
	endtask : t_reset
	task automatic t_freq();
		@(posedge clk_i);
		meas_f_i <= 16'h0032;
		ref_f_i <= 16'h003C;
		host.wr(PMC_OFS_GAIN_F, 16'h7530);
		host.cmd(16'h0002);
		wait_done();
		chk("ack_o", 24'h00_0001, {23'h0, ack_o});
		rchk("gain_f", PMC_OFS_GAIN_F, 16'h8CA0);
		$display("frequency test done");
	endtask : t_freq
	task automatic t_gain_nak();
		@(posedge clk_i);
		meas_i_i <= 16'h07D0;
		host.wr(PMC_OFS_EXP_I, 16'h03E8);
		host.wr(PMC_OFS_EXP_V, 16'h0001);
		host.wr(PMC_OFS_EXP_P, 16'h0001);
		host.cmd(16'h0001);
		wait_done();
		chk("ack_o", 24'h00_0000, {23'h0, ack_o});
		rchk("status", PMC_OFS_STATUS, 16'h0004);
		for (int k = 0; k < 3; k++)
			rchk("gain", PMC_OFS_GAIN_I + 4'(k), 16'h8000);
		$display("gain refusal test done");
	endtask : t_gain_nak
	task automatic t_gain_ack();
		@(posedge clk_i);
		meas_i_i <= 16'h1000;
		meas_p_i <= 16'h8000;
		meas_v_i <= 16'h0002;
		host.wr(PMC_OFS_EXP_I, 16'h0C35);
		host.wr(PMC_OFS_EXP_V, 16'h0003);
		host.wr(PMC_OFS_EXP_P, 16'hFFFF);
		host.cmd(16'h0001);
		host.wr(PMC_OFS_GAIN_V, 16'h1234);
		wait_done();
		chk("ack_o", 24'h00_0001, {23'h0, ack_o});
		rchk("status", PMC_OFS_STATUS, 16'h0002);
		rchk("gain_i", PMC_OFS_GAIN_I, 16'h61A8);
		rchk("gain_v", PMC_OFS_GAIN_V, 16'hC000);
		rchk("gain_p", PMC_OFS_GAIN_P, 16'hFFFF);
		$display("gain bounds test done");
	endtask : t_gain_ack
	task automatic t_range();
		@(posedge clk_i);
		irms_raw_i <= 24'h00_1000;
		for (int r = 11; r <= 13; r++) begin
			host.wr(PMC_OFS_RANGE, 16'(r));
			settle();
			chk("irms_o", 24'((64'd4096 * 64'd25000) >> r), irms_o);
		end
		$display("range test done");
	endtask : t_range
	task automatic t_phase();
		host.wr(PMC_OFS_PHASE, 16'hFF10);
		host.wr(PMC_OFS_PHASE_ADJ, host.phase_units(1));
		host.cmd(16'h0004);
		rchk("phase", PMC_OFS_PHASE, 16'h0038);
		host.wr(PMC_OFS_PHASE_ADJ, 16'h007F);
		host.cmd(16'h0004);
		rchk("phase", PMC_OFS_PHASE, 16'h007F);
		host.wr(PMC_OFS_PHASE, 16'h0080);
		host.wr(PMC_OFS_PHASE_ADJ, host.phase_units(-1));
		host.cmd(16'h0004);
		rchk("phase", PMC_OFS_PHASE, 16'h0080);
		$display("phase test done");
	endtask : t_phase
	task automatic t_offsets();
		@(posedge clk_i);
		adc_i_i <= 24'sd100;
		hpf_i_i <= 24'sd7;
		hpf_v_i <= 24'sd9;
		raw_v_i <= -24'sd5;
		host.wr(PMC_OFS_DC_OFS_I, 16'hFFF0);
		settle();
		chk("adc_i_corr_o", 24'h00_0054, adc_i_corr_o);
		chk("chan_i_o", 24'h00_0007, chan_i_o);
		chk("chan_v_o", 24'h00_0009, chan_v_o);
		host.wr(PMC_OFS_CTRL, 16'h0008);
		settle();
		chk("chan_i_o", 24'h00_0054, chan_i_o);
		chk("chan_v_o", 24'hFF_FFFB, chan_v_o);
		for (int k = 0; k < 3; k++)
			host.wr(PMC_OFS_AC_OFS_I + 4'(k), 16'h1110 * 16'(k + 1));
		for (int k = 0; k < 3; k++)
			rchk("ac_ofs", PMC_OFS_AC_OFS_I + 4'(k), 16'h1110 * 16'(k + 1));
		$display("offset test done");
	endtask : t_offsets
	initial begin
		adc_i_i <= '0;
		hpf_i_i <= '0;
		hpf_v_i <= '0;
		raw_v_i <= '0;
		meas_i_i <= 16'h0001;
		meas_v_i <= 16'h0001;
		meas_p_i <= 16'h0001;
		meas_f_i <= 16'h0001;
		ref_f_i <= 16'h0001;
		irms_raw_i <= '0;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_freq();
		t_gain_nak();
		t_gain_ack();
		t_range();
		t_phase();
		t_offsets();
		print_verdict();
	end
endmodule : tb
